// [bench/tb_top.sv]
`timescale 1ns/1ns
module tb_top
	import afc_pkg::*;
;
	typedef struct packed {
		logic [15:0] pc;
		logic [7:0] st;
		logic [2:0] n;
	} afc_note_t;

	logic ref_clk_i = 1'b0;
	logic reset_i = 1'b1;
	logic op_valid_i = 1'b0;
	afc_op_t op_code_i = OP_ADD;
	logic [4:0] dst_idx_i = 5'h00;
	logic [4:0] src_idx_i = 5'h00;
	logic [4:0] peek_idx_i = 5'h00;
	logic [1:0] pair_sel_i = 2'h0;
	logic [7:0] imm_i = 8'h00;
	logic [7:0] io_byte_i = 8'h00;
	logic [2:0] bit_sel_i = 3'h0;
	logic [6:0] offset_i = 7'h00;
	logic next_two_word_i = 1'b0;
	logic busy_o;
	logic done_o;
	logic [15:0] pc_o;
	logic [7:0] status_o;
	logic [7:0] peek_data_o;
	logic stack_fault_o;
	int error_cnt = 0;
	int checks = 0;
	int cyc = 0;
	int acc = 0;
	logic [31:0] seed = 32'hCF14;
	logic [7:0] rf [32];
	logic [7:0] st;
	logic [15:0] pc;
	logic [15:0] stk [$];
	afc_note_t notes [$];
	afc_note_t nt;

	afc_top dut (
		.ref_clk_i(ref_clk_i),
		.reset_i(reset_i),
		.op_valid_i(op_valid_i),
		.op_code_i(op_code_i),
		.dst_idx_i(dst_idx_i),
		.src_idx_i(src_idx_i),
		.pair_sel_i(pair_sel_i),
		.imm_i(imm_i),
		.bit_sel_i(bit_sel_i),
		.io_byte_i(io_byte_i),
		.offset_i(offset_i),
		.next_two_word_i(next_two_word_i),
		.peek_idx_i(peek_idx_i),
		.busy_o(busy_o),
		.done_o(done_o),
		.pc_o(pc_o),
		.status_o(status_o),
		.peek_data_o(peek_data_o),
		.stack_fault_o(stack_fault_o)
	);

	always #4 ref_clk_i = ~ref_clk_i;

	// ----------------------------------------
	// Reference model
	// ----------------------------------------
	function automatic logic [31:0] xs(input logic [31:0] v);
		logic [31:0] x;
		x = v ^ (v << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction

	function automatic void arith(input logic [7:0] a, input logic [7:0] b, input logic ci, input logic sub,
		input logic keep, input logic [4:0] d);
		logic [8:0] r;
		r = sub ? {1'b0, a} - {1'b0, b} - 9'(ci) : {1'b0, a} + {1'b0, b} + 9'(ci);
		st[FLAG_H] = sub ? {1'b0, a[3:0]} < {1'b0, b[3:0]} + 5'(ci) : {1'b0, a[3:0]} + {1'b0, b[3:0]} + 5'(ci) > 5'h0F;
		st[FLAG_V] = sub ? a[7] != b[7] && r[7] != a[7] : a[7] == b[7] && r[7] != a[7];
		st[FLAG_C] = r[8];
		st[FLAG_N] = r[7];
		st[FLAG_Z] = r[7:0] == 8'h00;
		if (keep)
			rf[d] = r[7:0];
	endfunction

	function automatic void logic_res(input logic [7:0] v, input logic [4:0] d);
		rf[d] = v;
		st[FLAG_Z] = v == 8'h00;
		st[FLAG_N] = v[7];
		st[FLAG_V] = 1'b0;
	endfunction

	function automatic void word(input logic [15:0] p, input logic [5:0] k, input logic sub, input int bs);
		logic [15:0] w;
		w = sub ? p - {10'h000, k} : p + {10'h000, k};
		rf[bs] = w[7:0];
		rf[bs + 1] = w[15:8];
		st[FLAG_C] = sub ? w[15] & ~p[15] : ~w[15] & p[15];
		st[FLAG_V] = sub ? p[15] & ~w[15] : ~p[15] & w[15];
		st[FLAG_N] = w[15];
		st[FLAG_Z] = w == 16'h0000;
		st[FLAG_S] = w[15] ^ st[FLAG_V];
	endfunction

	// ----------------------------------------
	// Drivers
	// ----------------------------------------
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic issue(input afc_op_t op, input logic [31:0] r, input logic [31:0] q);
		logic [4:0] d;
		logic [7:0] k;
		logic [7:0] a;
		logic [7:0] b;
		logic [15:0] w;
		logic [2:0] n;
		logic t;
		logic u;
		int bs;
		d = r[4:0];
		k = r[19:12];
		a = rf[d];
		b = rf[r[9:5]];
		bs = PAIR_BASE + 2 * r[11:10];
		n = 3'h1;
		t = 1'b0;
		u = 1'b0;
		w = pc + 16'h0001;
		case (op)
			OP_ADD: arith(a, b, 1'b0, 1'b0, 1'b1, d);
			OP_ADD_CARRY: arith(a, b, st[FLAG_C], 1'b0, 1'b1, d);
			OP_SUB: arith(a, b, 1'b0, 1'b1, 1'b1, d);
			OP_MINUS_CONSTANT: arith(a, k, 1'b0, 1'b1, 1'b1, d);
			OP_MINUS_WITH_BORROW: arith(a, b, st[FLAG_C], 1'b1, 1'b1, d);
			OP_MINUS_CONSTANT_WITH_BORROW: arith(a, k, st[FLAG_C], 1'b1, 1'b1, d);
			OP_COMPARE: arith(a, b, 1'b0, 1'b1, 1'b0, d);
			OP_COMPARE_CARRY: arith(a, b, st[FLAG_C], 1'b1, 1'b0, d);
			OP_IMMEDIATE_COMPARE: arith(a, k, 1'b0, 1'b1, 1'b0, d);
			OP_WORD_IMMEDIATE_SUM, OP_WORD_IMMEDIATE_MINUS: begin
				word({rf[bs + 1], rf[bs]}, k[5:0], op == OP_WORD_IMMEDIATE_MINUS, bs);
				n = 3'h2;
			end
			OP_AND: logic_res(a & b, d);
			OP_CONJUNCTION_CONSTANT: logic_res(a & k, d);
			OP_OR: logic_res(a | b, d);
			OP_DISJUNCTION_CONSTANT, OP_SET_MASK_BITS: logic_res(a | k, d);
			OP_EXCLUSIVE_DISJUNCTION: logic_res(a ^ b, d);
			OP_CLEAR_MASK_BITS: logic_res(a & (8'hFF - k), d);
			OP_ZERO_SIGN_TEST: logic_res(a & a, d);
			OP_POINTER_JUMP, OP_POINTER_CALL: begin
				if (op == OP_POINTER_CALL)
					stk.push_back(w);
				w = {rf[31], rf[30]};
				n = op == OP_POINTER_CALL ? 3'h3 : 3'h2;
			end
			OP_RETURN, OP_INTERRUPT_RETURN: begin
				w = stk.pop_back();
				st[FLAG_I] = st[FLAG_I] | (op == OP_INTERRUPT_RETURN);
				n = 3'h4;
			end
			OP_EQUAL_SKIP: t = a == b;
			OP_SKIP_REG_BIT_LOW: t = !b[r[22:20]];
			OP_SKIP_REG_BIT_HIGH: t = b[r[22:20]];
			OP_SKIP_IO_BIT_LOW: t = !q[8 + r[22:20]];
			OP_SKIP_IO_BIT_HIGH: t = q[8 + r[22:20]];
			OP_BRANCH_FLAG_HIGH: u = st[r[22:20]];
			OP_BRANCH_FLAG_LOW: u = !st[r[22:20]];
			OP_BRANCH_NO_BORROW: u = !st[FLAG_C];
			default: rf[d] = k;
		endcase
		if (t) begin
			w = pc + (q[7] ? 16'h0003 : 16'h0002);
			n = q[7] ? 3'h3 : 3'h2;
		end
		if (u) begin
			w = pc + 16'h0001 + {{9{q[6]}}, q[6:0]};
			n = 3'h2;
		end
		pc = w;
		notes.push_back('{w, st, n});
		op_valid_i <= 1'b1;
		op_code_i <= op;
		dst_idx_i <= d;
		src_idx_i <= r[9:5];
		pair_sel_i <= r[11:10];
		imm_i <= k;
		bit_sel_i <= r[22:20];
		io_byte_i <= q[15:8];
		offset_i <= q[6:0];
		next_two_word_i <= q[7];
		// Held while busy, so the repeats are refused
		repeat (n) @(posedge ref_clk_i);
	endtask

	task automatic scan();
		op_valid_i <= 1'b0;
		// Readback is registered: look mid-cycle after the loading edge
		for (int i = 0; i < 32; i++) begin
			peek_idx_i <= 5'(i);
			@(posedge ref_clk_i);
			@(negedge ref_clk_i);
			check({8'h00, peek_data_o}, {8'h00, rf[i]});
			@(posedge ref_clk_i);
		end
		check(pc_o, pc);
		check({8'h00, status_o}, {8'h00, st});
	endtask

	task automatic do_reset();
		op_valid_i <= 1'b0;
		reset_i <= 1'b1;
		repeat (6) @(posedge ref_clk_i);
		reset_i <= 1'b0;
		pc = PC_RESET;
		st = STATUS_RESET;
		stk.delete();
		foreach (rf[i])
			rf[i] = REG_RESET;
		scan();
	endtask

	task automatic stop_test();
		if (error_cnt == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// ----------------------------------------
	// Monitor
	// ----------------------------------------
	// Sampled mid-cycle so registered outputs have settled
	always @(negedge ref_clk_i) begin
		if (reset_i === 1'b0 && done_o === 1'b1) begin
			if (notes.size() == 0) begin
				error_cnt++;
				$display("[ERR] %0t completion with nothing pending", $time);
			end else begin
				nt = notes.pop_front();
				check(pc_o, nt.pc);
				check({8'h00, status_o}, {8'h00, nt.st});
				check(16'(cyc - acc), {13'h0000, nt.n});
				check({15'h0000, busy_o}, 16'h0000);
				check({15'h0000, stack_fault_o}, 16'h0000);
			end
		end
		if (reset_i === 1'b0 && op_valid_i === 1'b1 && busy_o === 1'b0)
			acc = cyc;
		cyc++;
	end

	// ----------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------
	initial begin
		logic [31:0] r;
		logic [31:0] q;
		afc_op_t op;
		do_reset();
		for (int i = 0; i < 3000; i++) begin
			seed = xs(seed);
			r = seed;
			seed = xs(seed);
			q = seed;
			op = afc_op_t'(r[29:25]);
			if (q[31])
				r[9:5] = r[4:0];
			if ((op == OP_RETURN || op == OP_INTERRUPT_RETURN) && stk.size() == 0)
				op = OP_LOAD_CONSTANT;
			if (op == OP_POINTER_CALL && stk.size() == STACK_DEPTH)
				op = OP_POINTER_JUMP;
			issue(op, r, q);
			if (i % 500 == 499)
				scan();
			if (i == 1499)
				do_reset();
		end
		check(16'(notes.size()), 16'h0000);
		stop_test();
	end

	initial begin
		#400000;
		error_cnt++;
		$display("[ERR] %0t watchdog expired", $time);
		stop_test();
	end
endmodule

// [rtl/afc_alu8.sv]
`timescale 1ns/1ns
module afc_alu8
	import afc_pkg::*;
(
	input wire logic [7:0] a_i,
	input wire logic [7:0] b_i,
	input wire logic carry_i,
	input wire afc_alu_t kind_i,
	output logic [7:0] res_o,
	output logic carry_o,
	output logic half_o,
	output logic ovf_o,
	output logic neg_o,
	output logic zero_o
);
	logic [8:0] wide;

	always_comb begin
		wide = 9'h000;
		half_o = 1'b0;
		ovf_o = 1'b0;
		case (kind_i)
			ALU_ADD: begin
				wide = {1'b0, a_i} + {1'b0, b_i} + {8'h00, carry_i};
				half_o = (a_i[3] & b_i[3]) | (b_i[3] & ~wide[3]) | (~wide[3] & a_i[3]);
				ovf_o = (a_i[7] & b_i[7] & ~wide[7]) | (~a_i[7] & ~b_i[7] & wide[7]);
			end
			ALU_SUB: begin
				wide = {1'b0, a_i} - {1'b0, b_i} - {8'h00, carry_i};
				half_o = (~a_i[3] & b_i[3]) | (b_i[3] & wide[3]) | (wide[3] & ~a_i[3]);
				ovf_o = (a_i[7] & ~b_i[7] & ~wide[7]) | (~a_i[7] & b_i[7] & wide[7]);
			end
			ALU_AND: wide = {1'b0, a_i & b_i};
			ALU_OR: wide = {1'b0, a_i | b_i};
			ALU_XOR: wide = {1'b0, a_i ^ b_i};
			default: wide = 9'h000;
		endcase
		res_o = wide[7:0];
		carry_o = wide[8];
		neg_o = wide[7];
		zero_o = (wide[7:0] == 8'h00);
	end
endmodule

// [rtl/afc_pkg.sv]
package afc_pkg;

	// ----------------------------------------
	// Operation codes
	// ----------------------------------------
	typedef enum logic [5:0] {
		OP_ADD, OP_ADD_CARRY, OP_WORD_IMMEDIATE_SUM, OP_SUB, OP_MINUS_CONSTANT,
		OP_MINUS_WITH_BORROW, OP_MINUS_CONSTANT_WITH_BORROW, OP_WORD_IMMEDIATE_MINUS,
		OP_AND, OP_CONJUNCTION_CONSTANT, OP_OR, OP_DISJUNCTION_CONSTANT, OP_EXCLUSIVE_DISJUNCTION,
		OP_SET_MASK_BITS, OP_CLEAR_MASK_BITS, OP_ZERO_SIGN_TEST,
		OP_POINTER_JUMP, OP_POINTER_CALL, OP_RETURN, OP_INTERRUPT_RETURN,
		OP_EQUAL_SKIP, OP_COMPARE, OP_COMPARE_CARRY, OP_IMMEDIATE_COMPARE,
		OP_SKIP_REG_BIT_LOW, OP_SKIP_REG_BIT_HIGH, OP_SKIP_IO_BIT_LOW, OP_SKIP_IO_BIT_HIGH,
		OP_BRANCH_FLAG_HIGH, OP_BRANCH_FLAG_LOW, OP_BRANCH_NO_BORROW, OP_LOAD_CONSTANT
	} afc_op_t;

	typedef enum logic [2:0] {ALU_ADD, ALU_SUB, ALU_AND, ALU_OR, ALU_XOR} afc_alu_t;

	// ----------------------------------------
	// Status flag positions and groups
	// ----------------------------------------
	localparam int FLAG_C = 0;
	localparam int FLAG_Z = 1;
	localparam int FLAG_N = 2;
	localparam int FLAG_V = 3;
	localparam int FLAG_S = 4;
	localparam int FLAG_H = 5;
	localparam int FLAG_I = 7;
	localparam logic [7:0] MASK_ARITH = 8'h2F;
	localparam logic [7:0] MASK_WORD = 8'h1F;
	localparam logic [7:0] MASK_LOGIC = 8'h0E;
	localparam logic [7:0] MASK_ALL_BITS = 8'hFF;

	// ----------------------------------------
	// Reset values and sizes
	// ----------------------------------------
	localparam logic [15:0] PC_RESET = 16'h0000;
	localparam logic [7:0] STATUS_RESET = 8'h00;
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam int REG_COUNT = 32;
	localparam int STACK_DEPTH = 16;
	localparam logic [4:0] PAIR_BASE = 5'h18;
	localparam logic [4:0] POINTER_LOW = 5'h1E;
	localparam logic [4:0] POINTER_HIGH = 5'h1F;

	// ----------------------------------------
	// Cycle counts
	// ----------------------------------------
	localparam logic [2:0] CYC_BYTE_OP = 3'h1;
	localparam logic [2:0] CYC_WORD_OP = 3'h2;
	localparam logic [2:0] CYC_POINTER_JUMP = 3'h2;
	localparam logic [2:0] CYC_POINTER_CALL = 3'h3;
	localparam logic [2:0] CYC_RETURN = 3'h4;
	localparam logic [2:0] CYC_BRANCH_TAKEN = 3'h2;
	localparam logic [2:0] CYC_SKIP_ONE = 3'h2;
	localparam logic [2:0] CYC_SKIP_TWO = 3'h3;
	localparam logic [15:0] PC_SKIP_ONE = 16'h0002;
	localparam logic [15:0] PC_SKIP_TWO = 16'h0003;

endpackage

// [rtl/afc_top.sv]
// Behaviour
// - Add, add-with-carry: store sum, five flags, one cycle
// - Word immediate sum on pair, two cycles
// - Subtract register or constant, five flags
// - Register minus with borrow, five flags
// - Constant minus with borrow, five flags
// - Word immediate minus on pair, two cycles
// - Conjunction: Z,N,V only, carry untouched
// - Disjunction or exclusive: Z,N,V only
// - Set mask bits ORs immediate, Z,N,V
// - Clear mask bits ANDs with inverted mask
// - Zero/sign test keeps register, Z,N,V
// - Pointer jump loads PC from Z, two cycles
// - Pointer call loads PC from Z, three cycles
// - Equal skip jumps past next instruction
// - Compares set flags without storing result
// - Skip when register bit is low
// - Skip when register bit is high
// - Skip when I/O bit is low
// - Skip when I/O bit is high
// - Branch when selected flag set: PC+k+1
// - Branch when selected flag clear: PC+k+1
// - Branch when carry clear, one or two cycles
`timescale 1ns/1ns
module afc_top
	import afc_pkg::*;
(
	input wire logic ref_clk_i,
	input wire logic reset_i,
	input wire logic op_valid_i,
	input wire afc_op_t op_code_i,
	input wire logic [4:0] dst_idx_i,
	input wire logic [4:0] src_idx_i,
	input wire logic [1:0] pair_sel_i,
	input wire logic [7:0] imm_i,
	input wire logic [2:0] bit_sel_i,
	input wire logic [7:0] io_byte_i,
	input wire logic [6:0] offset_i,
	input wire logic next_two_word_i,
	input wire logic [4:0] peek_idx_i,
	output logic busy_o,
	output logic done_o,
	output logic [15:0] pc_o,
	output logic [7:0] status_o,
	output logic [7:0] peek_data_o,
	output logic stack_fault_o
);
	// ----------------------------------------
	// State
	// ----------------------------------------
	logic [7:0] rf [REG_COUNT];
	logic [15:0] ret_stack [STACK_DEPTH];
	logic [4:0] sp_reg;
	logic [15:0] pc_reg;
	logic [7:0] status_reg;
	logic busy_reg;
	logic done_reg;
	logic [2:0] cnt_reg;
	logic [7:0] peek_reg;
	logic stack_fault_reg;

	// ----------------------------------------
	// Operand fetch
	// ----------------------------------------
	logic accept;
	logic [7:0] dst_val;
	logic [7:0] src_val;
	logic [4:0] pair_lo;
	logic [4:0] pair_hi;
	logic [15:0] pair_val;
	logic [15:0] pointer_val;
	logic [15:0] pc_plus1;
	logic [15:0] branch_target;

	assign accept = op_valid_i && !busy_reg;
	assign dst_val = rf[dst_idx_i];
	assign src_val = rf[src_idx_i];
	assign pair_lo = PAIR_BASE + {2'b00, pair_sel_i, 1'b0};
	assign pair_hi = pair_lo + 5'h01;
	assign pair_val = {rf[pair_hi], rf[pair_lo]};
	assign pointer_val = {rf[POINTER_HIGH], rf[POINTER_LOW]};
	assign pc_plus1 = pc_reg + 16'h0001;
	assign branch_target = pc_plus1 + {{9{offset_i[6]}}, offset_i};

	// ----------------------------------------
	// Arithmetic units
	// ----------------------------------------
	logic [7:0] alu_a;
	logic [7:0] alu_b;
	logic alu_cin;
	afc_alu_t alu_kind;
	logic [7:0] alu_res;
	logic alu_c;
	logic alu_h;
	logic alu_v;
	logic alu_n;
	logic alu_z;
	logic word_sub;
	logic [15:0] word_res;
	logic word_c;
	logic word_v;
	logic word_n;
	logic word_z;
	logic word_s;

	afc_alu8 u_alu (
		.a_i(alu_a),
		.b_i(alu_b),
		.carry_i(alu_cin),
		.kind_i(alu_kind),
		.res_o(alu_res),
		.carry_o(alu_c),
		.half_o(alu_h),
		.ovf_o(alu_v),
		.neg_o(alu_n),
		.zero_o(alu_z)
	);

	afc_word_unit u_word (
		.pair_i(pair_val),
		.imm_i(imm_i[5:0]),
		.sub_i(word_sub),
		.res_o(word_res),
		.carry_o(word_c),
		.ovf_o(word_v),
		.neg_o(word_n),
		.zero_o(word_z),
		.sign_o(word_s)
	);

	// ----------------------------------------
	// Operation decode
	// ----------------------------------------
	logic wr8_en;
	logic wr16_en;
	logic [7:0] wr8_data;
	logic [7:0] flag_mask;
	logic [7:0] flag_new;
	logic [7:0] byte_flags;
	logic [7:0] word_flags;
	logic [15:0] pc_next;
	logic [2:0] cycles;
	logic push;
	logic pop;
	logic set_ie;
	logic skip_cond;
	logic branch_cond;
	logic [7:0] status_next;

	assign byte_flags = {2'b00, alu_h, 1'b0, alu_v, alu_n, alu_z, alu_c};
	assign word_flags = {3'b000, word_s, word_v, word_n, word_z, word_c};

	always_comb begin
		alu_a = dst_val;
		alu_b = src_val;
		alu_cin = 1'b0;
		alu_kind = ALU_ADD;
		word_sub = 1'b0;
		wr8_en = 1'b0;
		wr16_en = 1'b0;
		wr8_data = alu_res;
		flag_mask = 8'h00;
		flag_new = byte_flags;
		skip_cond = 1'b0;
		branch_cond = 1'b0;
		push = 1'b0;
		pop = 1'b0;
		set_ie = 1'b0;
		case (op_code_i)
			OP_ADD, OP_ADD_CARRY: begin
				alu_cin = (op_code_i == OP_ADD_CARRY) & status_reg[FLAG_C];
				wr8_en = 1'b1;
				flag_mask = MASK_ARITH;
			end
			OP_WORD_IMMEDIATE_SUM, OP_WORD_IMMEDIATE_MINUS: begin
				word_sub = (op_code_i == OP_WORD_IMMEDIATE_MINUS);
				wr16_en = 1'b1;
				flag_new = word_flags;
				flag_mask = MASK_WORD;
			end
			OP_SUB, OP_MINUS_CONSTANT: begin
				alu_kind = ALU_SUB;
				alu_b = (op_code_i == OP_MINUS_CONSTANT) ? imm_i : src_val;
				wr8_en = 1'b1;
				flag_mask = MASK_ARITH;
			end
			OP_MINUS_WITH_BORROW, OP_MINUS_CONSTANT_WITH_BORROW: begin
				alu_kind = ALU_SUB;
				alu_b = (op_code_i == OP_MINUS_CONSTANT_WITH_BORROW) ? imm_i : src_val;
				alu_cin = status_reg[FLAG_C];
				wr8_en = 1'b1;
				flag_mask = MASK_ARITH;
			end
			OP_AND, OP_CONJUNCTION_CONSTANT: begin
				alu_kind = ALU_AND;
				alu_b = (op_code_i == OP_CONJUNCTION_CONSTANT) ? imm_i : src_val;
				wr8_en = 1'b1;
				flag_mask = MASK_LOGIC;
			end
			OP_OR, OP_DISJUNCTION_CONSTANT, OP_SET_MASK_BITS: begin
				alu_kind = ALU_OR;
				alu_b = (op_code_i == OP_OR) ? src_val : imm_i;
				wr8_en = 1'b1;
				flag_mask = MASK_LOGIC;
			end
			OP_EXCLUSIVE_DISJUNCTION: begin
				alu_kind = ALU_XOR;
				wr8_en = 1'b1;
				flag_mask = MASK_LOGIC;
			end
			OP_CLEAR_MASK_BITS: begin
				alu_kind = ALU_AND;
				alu_b = MASK_ALL_BITS - imm_i;
				wr8_en = 1'b1;
				flag_mask = MASK_LOGIC;
			end
			OP_ZERO_SIGN_TEST: begin
				alu_kind = ALU_AND;
				alu_b = dst_val;
				flag_mask = MASK_LOGIC;
			end
			OP_COMPARE, OP_COMPARE_CARRY, OP_IMMEDIATE_COMPARE: begin
				alu_kind = ALU_SUB;
				alu_b = (op_code_i == OP_IMMEDIATE_COMPARE) ? imm_i : src_val;
				alu_cin = (op_code_i == OP_COMPARE_CARRY) & status_reg[FLAG_C];
				flag_mask = MASK_ARITH;
			end
			OP_POINTER_CALL: push = 1'b1;
			OP_RETURN: pop = 1'b1;
			OP_INTERRUPT_RETURN: begin
				pop = 1'b1;
				set_ie = 1'b1;
			end
			OP_EQUAL_SKIP: skip_cond = (dst_val == src_val);
			OP_SKIP_REG_BIT_LOW: skip_cond = !src_val[bit_sel_i];
			OP_SKIP_REG_BIT_HIGH: skip_cond = src_val[bit_sel_i];
			OP_SKIP_IO_BIT_LOW: skip_cond = !io_byte_i[bit_sel_i];
			OP_SKIP_IO_BIT_HIGH: skip_cond = io_byte_i[bit_sel_i];
			OP_BRANCH_FLAG_HIGH: branch_cond = status_reg[bit_sel_i];
			OP_BRANCH_FLAG_LOW: branch_cond = !status_reg[bit_sel_i];
			OP_BRANCH_NO_BORROW: branch_cond = !status_reg[FLAG_C];
			OP_LOAD_CONSTANT: begin
				wr8_en = 1'b1;
				wr8_data = imm_i;
			end
			default: flag_mask = 8'h00;
		endcase
	end

	// Program counter and cycle count per operation
	always_comb begin
		pc_next = pc_plus1;
		cycles = CYC_BYTE_OP;
		case (op_code_i)
			OP_WORD_IMMEDIATE_SUM, OP_WORD_IMMEDIATE_MINUS: cycles = CYC_WORD_OP;
			OP_POINTER_JUMP: begin
				pc_next = pointer_val;
				cycles = CYC_POINTER_JUMP;
			end
			OP_POINTER_CALL: begin
				pc_next = pointer_val;
				cycles = CYC_POINTER_CALL;
			end
			OP_RETURN, OP_INTERRUPT_RETURN: begin
				pc_next = (sp_reg != 5'h00) ? ret_stack[4'(sp_reg - 5'h01)] : pc_plus1;
				cycles = CYC_RETURN;
			end
			OP_EQUAL_SKIP, OP_SKIP_REG_BIT_LOW, OP_SKIP_REG_BIT_HIGH, OP_SKIP_IO_BIT_LOW, OP_SKIP_IO_BIT_HIGH: begin
				if (skip_cond) begin
					pc_next = pc_reg + (next_two_word_i ? PC_SKIP_TWO : PC_SKIP_ONE);
					cycles = next_two_word_i ? CYC_SKIP_TWO : CYC_SKIP_ONE;
				end
			end
			OP_BRANCH_FLAG_HIGH, OP_BRANCH_FLAG_LOW, OP_BRANCH_NO_BORROW: begin
				if (branch_cond) begin
					pc_next = branch_target;
					cycles = CYC_BRANCH_TAKEN;
				end
			end
			default: pc_next = pc_plus1;
		endcase
	end

	// Unlisted flags keep their value
	always_comb begin
		status_next = (status_reg & ~flag_mask) | (flag_new & flag_mask);
		if (set_ie) begin
			status_next[FLAG_I] = 1'b1;
		end
	end

	// ----------------------------------------
	// Register file
	// ----------------------------------------
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			for (int i = 0; i < REG_COUNT; i++) begin
				rf[i] <= REG_RESET;
			end
		end else if (accept && wr8_en) begin
			rf[dst_idx_i] <= wr8_data;
		end else if (accept && wr16_en) begin
			rf[pair_lo] <= word_res[7:0];
			rf[pair_hi] <= word_res[15:8];
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			peek_reg <= REG_RESET;
		end else begin
			peek_reg <= rf[peek_idx_i];
		end
	end

	// ----------------------------------------
	// Status flags and program counter
	// ----------------------------------------
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			status_reg <= STATUS_RESET;
			pc_reg <= PC_RESET;
		end else if (accept) begin
			status_reg <= status_next;
			pc_reg <= pc_next;
		end
	end

	// ----------------------------------------
	// Return address stack
	// ----------------------------------------
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			sp_reg <= 5'h00;
			stack_fault_reg <= 1'b0;
		end else if (accept && push) begin
			if (sp_reg == 5'(STACK_DEPTH)) begin
				stack_fault_reg <= 1'b1;
			end else begin
				ret_stack[sp_reg[3:0]] <= pc_plus1;
				sp_reg <= sp_reg + 5'h01;
			end
		end else if (accept && pop) begin
			if (sp_reg == 5'h00) begin
				stack_fault_reg <= 1'b1;
			end else begin
				sp_reg <= sp_reg - 5'h01;
			end
		end
	end

	// ----------------------------------------
	// Cycle sequencing
	// ----------------------------------------
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			cnt_reg <= 3'h0;
			busy_reg <= 1'b0;
			done_reg <= 1'b0;
		end else if (accept) begin
			cnt_reg <= cycles - 3'h1;
			busy_reg <= (cycles != CYC_BYTE_OP);
			done_reg <= (cycles == CYC_BYTE_OP);
		end else begin
			cnt_reg <= (cnt_reg != 3'h0) ? cnt_reg - 3'h1 : 3'h0;
			busy_reg <= (cnt_reg > 3'h1);
			done_reg <= (cnt_reg == 3'h1);
		end
	end

	assign busy_o = busy_reg;
	assign done_o = done_reg;
	assign pc_o = pc_reg;
	assign status_o = status_reg;
	assign peek_data_o = peek_reg;
	assign stack_fault_o = stack_fault_reg;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (reset_i);

	property p_add_result;
		accept && op_code_i == OP_ADD && dst_idx_i != src_idx_i
			|=> rf[$past(dst_idx_i)] == 8'($past(dst_val) + $past(src_val));
	endproperty
	a_add_result: assert property (p_add_result) else $error("sum not stored");

	property p_word_two_cycles;
		accept && op_code_i == OP_WORD_IMMEDIATE_SUM |=> busy_o ##1 !busy_o && done_o;
	endproperty
	a_word_two_cycles: assert property (p_word_two_cycles) else $error("word sum not two cycles");

	property p_minus_const;
		accept && op_code_i == OP_MINUS_CONSTANT |=> rf[$past(dst_idx_i)] == 8'($past(dst_val) - $past(imm_i));
	endproperty
	a_minus_const: assert property (p_minus_const) else $error("difference wrong");

	property p_logic_keeps_carry;
		accept && op_code_i inside {OP_AND, OP_CONJUNCTION_CONSTANT} |=> $stable(status_o[FLAG_C]) && !status_o[FLAG_V];
	endproperty
	a_logic_keeps_carry: assert property (p_logic_keeps_carry) else $error("conjunction touched carry");

	property p_test_keeps_reg;
		accept && op_code_i == OP_ZERO_SIGN_TEST
			|=> rf[$past(dst_idx_i)] == $past(dst_val) && status_o[FLAG_Z] == ($past(dst_val) == 8'h00);
	endproperty
	a_test_keeps_reg: assert property (p_test_keeps_reg) else $error("test altered register");

	property p_call_three;
		accept && op_code_i == OP_POINTER_CALL |=> pc_o == $past(pointer_val) ##0 busy_o [*2] ##1 !busy_o;
	endproperty
	a_call_three: assert property (p_call_three) else $error("pointer call timing");

	property p_skip_pc;
		accept && op_code_i == OP_EQUAL_SKIP && dst_val == src_val
			|=> pc_o == $past(pc_o) + ($past(next_two_word_i) ? 16'h0003 : 16'h0002) && $stable(status_o);
	endproperty
	a_skip_pc: assert property (p_skip_pc) else $error("skip target wrong");

	property p_branch_taken;
		accept && op_code_i == OP_BRANCH_FLAG_HIGH && status_reg[bit_sel_i]
			|=> pc_o == $past(branch_target) && busy_o ##1 !busy_o;
	endproperty
	a_branch_taken: assert property (p_branch_taken) else $error("branch not taken");

	property p_branch_idle;
		accept && op_code_i == OP_BRANCH_NO_BORROW && status_reg[FLAG_C] |=> pc_o == $past(pc_plus1) && !busy_o;
	endproperty
	a_branch_idle: assert property (p_branch_idle) else $error("branch taken on carry");

	property p_interrupt_return_sets_i;
		accept && op_code_i == OP_INTERRUPT_RETURN |=> status_o[FLAG_I] ##1 busy_o [*2] ##1 !busy_o;
	endproperty
	a_interrupt_return_sets_i: assert property (p_interrupt_return_sets_i) else $error("interrupt return flag");

	c_word_minus: cover property (accept && op_code_i == OP_WORD_IMMEDIATE_MINUS);
	c_skip_two: cover property (accept && op_code_i == OP_SKIP_IO_BIT_HIGH && io_byte_i[bit_sel_i] && next_two_word_i);
	c_call_return: cover property (accept && op_code_i == OP_POINTER_CALL ##[3:20] accept && op_code_i == OP_RETURN);
endmodule

// [rtl/afc_word_unit.sv]
`timescale 1ns/1ns
module afc_word_unit (
	input wire logic [15:0] pair_i,
	input wire logic [5:0] imm_i,
	input wire logic sub_i,
	output logic [15:0] res_o,
	output logic carry_o,
	output logic ovf_o,
	output logic neg_o,
	output logic zero_o,
	output logic sign_o
);
	always_comb begin
		if (sub_i) begin
			res_o = pair_i - {10'h000, imm_i};
			ovf_o = pair_i[15] & ~res_o[15];
			carry_o = res_o[15] & ~pair_i[15];
		end else begin
			res_o = pair_i + {10'h000, imm_i};
			ovf_o = ~pair_i[15] & res_o[15];
			carry_o = ~res_o[15] & pair_i[15];
		end
		neg_o = res_o[15];
		zero_o = (res_o == 16'h0000);
		sign_o = res_o[15] ^ ovf_o;
	end
endmodule
